// ### test/rxw_exec_chk.sv
// port assertions for the swap and watchdog-test executor
`timescale 1ns/100ps
module rxw_exec_chk
    import rxw_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [3:0] ram_rd_data,
    input wire logic wdt_flag_set,
    input wire rxw_pkg::rxw_regs_s regs_q,
    input wire logic ram_wr_en_q,
    input wire logic [3:0] ram_wr_data_q,
    input wire logic watchdog_flag_one_q,
    input wire logic watchdog_run_q,
    input wire logic skip_next_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // taken word, split by kind
    wire tk = clk_en && instr_valid && !skip_next_q;
    wire sd = tk && instr_word[9:4] == RXW_OP_SWAPD_HI;
    wire sw = sd || (tk && instr_word[9:4] == RXW_OP_SWAP_HI);
    wire wt = tk && instr_word == RXW_OP_WDT_TEST;
    property p_swap;
        sw |=> regs_q.acc == $past(ram_rd_data) && ram_wr_en_q
            && ram_wr_data_q == $past(regs_q.acc);
    endproperty
    a_swap: assert property (p_swap) else $error("swap result wrong");
    property p_xor;
        sw |=> regs_q.x == ($past(regs_q.x) ^ $past(instr_word[3:0]));
    endproperty
    a_xor: assert property (p_xor) else $error("x update wrong");
    property p_dec;
        sd |=> regs_q.y == $past(regs_q.y) - 4'h1 && skip_next_q == (regs_q.y == RXW_Y_WRAP);
    endproperty
    a_dec: assert property (p_dec) else $error("y decrement wrong");
    property p_wskip;
        wt && watchdog_flag_one_q && !wdt_flag_set |=> skip_next_q && !watchdog_flag_one_q;
    endproperty
    a_wskip: assert property (p_wskip) else $error("flag test skip wrong");
    property p_wrun;
        wt && !watchdog_flag_one_q |=> !skip_next_q;
    endproperty
    a_wrun: assert property (p_wrun) else $error("flag test skipped");
    property p_stop;
        tk && instr_word == RXW_OP_WDT_DIS ##1 wt |=> !watchdog_run_q;
    endproperty
    a_stop: assert property (p_stop) else $error("watchdog not stopped");
    // a skipped word must leave no trace
    property p_skip;
        skip_next_q && clk_en && instr_valid |=> !skip_next_q && !ram_wr_en_q
            && $stable(regs_q.acc);
    endproperty
    a_skip: assert property (p_skip) else $error("skipped word acted");
    property p_pulse;
        ram_wr_en_q |-> ($past(clk_en) ? $past(sw) : $stable(ram_wr_en_q));
    endproperty
    a_pulse: assert property (p_pulse) else $error("stray ram write");
    // enable low must freeze regs, skip, write strobe, flag one and run (write data not checked)
    property p_freeze;
        !clk_en |=> $stable(regs_q) && $stable(skip_next_q) && $stable(ram_wr_en_q)
            && $stable(watchdog_flag_one_q) && $stable(watchdog_run_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen cycle changed state");
endmodule

// ### test/rxw_exec_test.sv
// self-checking bench for the swap and watchdog-test executor
`timescale 1ns/100ps
module rxw_exec_test;
    import rxw_pkg::*;
    logic clock = 0, rstn = 0, iv = 0, fs = 0, wr, f1, run, sk;
    logic [9:0] w = 0;
    logic [3:0] r = 0, wd, ewd = 0, em = 0, ea = 0, ex = 0, ey = 0;
    logic ef = 0, er = 1, es = 0, pd = 0, ce = 1, ew = 0, ee = 0, eo;
    logic [31:0] s = 50;
    int mismatches = 0, checked = 0;
    rxw_regs_s q;
    rxw_exec dut (.clock(clock), .rstn(rstn), .clk_en(ce), .instr_valid(iv),
        .instr_word(w), .ram_rd_data(r), .wdt_flag_set(fs), .regs_q(q), .ram_wr_en_q(wr),
        .ram_wr_data_q(wd), .watchdog_flag_one_q(f1), .watchdog_run_q(run),
        .skip_next_q(sk), .executed_q(eo));
    always #50 clock = ~clock;
    function automatic logic [31:0] nx(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (e !== g) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // one word per cycle, valid held so words run back to back; ce low freezes
    task automatic op;
        iv = 1;
        @(negedge clock);
        if (ce) begin
            ewd = ea;
            ew = 0;
            ee = !es;
            em = r;
            if (es) es = 0;
            else begin
                if (w[9:4] == RXW_OP_SWAP_HI || w[9:4] == RXW_OP_SWAPD_HI) begin
                    ea = r;
                    ex ^= w[3:0];
                    ew = 1;
                    if (w[9:4] == RXW_OP_SWAPD_HI) es = (--ey == RXW_Y_WRAP);
                end
                if (w == RXW_OP_WDT_TEST) begin
                    es = ef;
                    er &= !pd;
                    ef = 0;
                end
                pd = (w == RXW_OP_WDT_DIS);
            end
            ef |= fs;
        end
        cmp("ram write", {ewd, ew}, {wd, wr});
        cmp("executed", ee, eo);
        cmp("state", {ea, ex, ey, em, es, ef, er}, {q.acc, q.x, q.y, q.mem, sk, f1, run});
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
    // corners first: wrap skip, flag skip after disable, then random mix
    initial begin
        logic [9:0] cw [5] = '{10'h2f0, 10'h2d5, 10'h29c, 10'h2a0, 10'h2a0};
        repeat (12) @(negedge clock);
        rstn = 1;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 5; i++) begin
            w = cw[i];
            fs = (i == 1);
            r = 4'h9;
            op();
        end
        repeat (300) begin
            s = nx(s);
            {fs, r, w} = {&s[16:14], s[13:0]};
            ce = |s[21:20];
            case (s[19:17])
                0: w = RXW_OP_WDT_TEST;
                1: w = RXW_OP_WDT_DIS;
                2, 3: w[9:4] = RXW_OP_SWAP_HI;
                4, 5: w[9:4] = RXW_OP_SWAPD_HI;
                default: ;
            endcase
            op();
        end
        print_verdict();
    end
endmodule
bind rxw_exec rxw_exec_chk chk (.*);

// ### verilog/rxw_exec.sv
// executor for watchdog test-and-skip, acc/mem swap, swap with Y decrement
// Contract
// - watchdog test with flag one set skips the following instruction.
// - that same test clears watchdog flag one to zero, unless a hardware set comes in the same cycle.
// - watchdog test with flag clear lets the next instruction execute.
// - watchdog test right after watchdog disable stops the watchdog.
// - swap exchanges accumulator with RAM word at the data pointer.
// - swap then XORs X with the 4-bit immediate into X.
// - decrement variant also decrements Y, skips when Y becomes fifteen.
`timescale 1ns/100ps
module rxw_exec (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    // one instruction word per enabled cycle when instr_valid is high
    input wire logic instr_valid,
    input wire logic [rxw_pkg::RXW_WORD_W-1:0] instr_word,
    input wire logic [3:0] ram_rd_data,
    input wire logic wdt_flag_set,
    output rxw_pkg::rxw_regs_s regs_q,
    output logic ram_wr_en_q,
    output logic [3:0] ram_wr_data_q,
    output logic watchdog_flag_one_q,
    output logic watchdog_run_q,
    output logic skip_next_q,
    output logic executed_q
);
    import rxw_pkg::*;

    // how the core uses this block:
    // - one word is offered per enabled cycle with instr_valid high
    // - ram_rd_data is the nibble at the data pointer, already settled
    // - ram_wr_en_q with ram_wr_data_q is the write half of the swap
    // - skip_next_q tells the fetch side that the next word is dropped
    // - executed_q marks every word that really ran, skipped ones not
    // - clk_en low freezes everything, the reset synchroniser aside
    // limitations:
    // - words other than the four handled here only clear a skip
    // - the watchdog counter lives outside; only its flag and run
    //   request are kept here
    // - data pointer addressing is the caller's job

    // only a 10-bit word with a 4-bit immediate is decoded by this logic
    if (RXW_WORD_W != 10 || RXW_NIB_W != 4) begin : g_width_check
        $error("rxw_exec: word or nibble width not supported");
    end

    logic rst_s1_q;
    logic rst_n_q;
    logic prev_dis_q;
    rxw_op_e op;
    logic run_now;
    logic [3:0] imm;

    // reset release through two flops; assertion stays asynchronous so
    // the core stops at once, while leaving reset waits for a clean edge
    // and every flop below sees the release on the same clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // the test is matched on the whole word; the swaps only on the upper
    // six bits, since the low nibble carries their immediate
    function automatic rxw_op_e rxw_decode(input logic [9:0] w);
        if (w == RXW_OP_WDT_TEST) begin
            rxw_decode = RXW_OP_WT;
        end else if (w[9:4] == RXW_OP_SWAP_HI) begin
            rxw_decode = RXW_OP_SW;
        end else if (w[9:4] == RXW_OP_SWAPD_HI) begin
            rxw_decode = RXW_OP_SWD;
        end else begin
            rxw_decode = RXW_OP_NONE;
        end
    endfunction

    // both swap forms share the exchange, the ram write and the xor
    function automatic logic rxw_is_swap(input rxw_op_e o);
        rxw_is_swap = (o == RXW_OP_SW) || (o == RXW_OP_SWD);
    endfunction

    // Y one lower; four bits, so zero wraps round to fifteen
    function automatic logic [3:0] rxw_y_dec(input logic [3:0] y);
        rxw_y_dec = y - 4'h1;
    endfunction

    // a skipped word is swallowed here, so it never executes; gating
    // with the enable keeps a frozen cycle from being counted as a word
    assign run_now = clk_en && instr_valid && !skip_next_q;
    assign op = run_now ? rxw_decode(instr_word) : RXW_OP_NONE;
    // immediate is cut from every word; only the swaps look at it
    assign imm = instr_word[3:0];

    // register updates: swap and immediate xor, Y decrement for the variant;
    // mem mirrors the RAM word of every enabled cycle for observation
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            regs_q <= '{acc: RXW_NIB_RST, x: RXW_NIB_RST, y: RXW_NIB_RST, mem: RXW_NIB_RST};
        end else if (clk_en) begin
            regs_q.mem <= ram_rd_data;
            if (rxw_is_swap(op)) begin
                regs_q.acc <= ram_rd_data;
                regs_q.x <= regs_q.x ^ imm;
            end
            if (op == RXW_OP_SWD) begin
                regs_q.y <= rxw_y_dec(regs_q.y);
            end
        end
    end

    // write strobe: one enabled cycle per swap, so the RAM sees one write;
    // a frozen cycle holds it, the RAM side must honour the same enable
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ram_wr_en_q <= 1'b0;
        end else if (clk_en) begin
            ram_wr_en_q <= rxw_is_swap(op);
        end
    end

    // old accumulator goes back to RAM at the data pointer; loaded every
    // enabled cycle to save a mux, the strobe alone says when it counts
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ram_wr_data_q <= RXW_NIB_RST;
        end else if (clk_en) begin
            ram_wr_data_q <= regs_q.acc;
        end
    end

    // skip request for the next word; any other taken word, and the
    // swallowed word itself, clears it, so a skip never spans two words
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            skip_next_q <= 1'b0;
        end else if (clk_en && instr_valid) begin
            case (op)
                RXW_OP_WT: begin
                    skip_next_q <= watchdog_flag_one_q;
                end
                RXW_OP_SWD: begin
                    skip_next_q <= rxw_y_dec(regs_q.y) == RXW_Y_WRAP;
                end
                default: begin
                    skip_next_q <= 1'b0;
                end
            endcase
        end
    end

    // one pulse for each word that really ran, skipped words excluded
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            executed_q <= 1'b0;
        end else if (clk_en) begin
            executed_q <= run_now;
        end
    end

    // flag one: hardware set wins over the clear by the test, so a
    // watchdog event in the same cycle as the test is never lost
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            watchdog_flag_one_q <= 1'b0;
        end else if (clk_en) begin
            if (wdt_flag_set) begin
                watchdog_flag_one_q <= 1'b1;
            end else if (op == RXW_OP_WT && watchdog_flag_one_q) begin
                watchdog_flag_one_q <= 1'b0;
            end
        end
    end

    // memory of the word before: only a disable that really ran counts,
    // and a gap with no valid word keeps it, as the core was idle then
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prev_dis_q <= 1'b0;
        end else if (clk_en && instr_valid) begin
            prev_dis_q <= run_now && (instr_word == RXW_OP_WDT_DIS);
        end
    end

    // watchdog stop needs disable immediately before the test; sticky
    // until reset, since nothing here may restart the counter
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            watchdog_run_q <= RXW_WDT_RUN_RST;
        end else if (clk_en && op == RXW_OP_WT && prev_dis_q) begin
            watchdog_run_q <= 1'b0;
        end
    end
endmodule

// ### verilog/rxw_pkg.sv
// shared constants and carriers for the swap and watchdog-test executor
package rxw_pkg;
    localparam int unsigned RXW_WORD_W = 10;
    localparam int unsigned RXW_NIB_W = 4;
    // opcode patterns, immediate in bits 3..0
    localparam logic [9:0] RXW_OP_WDT_TEST = 10'h2a0;
    localparam logic [9:0] RXW_OP_WDT_DIS = 10'h29c;
    localparam logic [5:0] RXW_OP_SWAP_HI = 6'h2d;
    localparam logic [5:0] RXW_OP_SWAPD_HI = 6'h2f;
    localparam logic [3:0] RXW_Y_WRAP = 4'hf;
    localparam logic [3:0] RXW_NIB_RST = 4'h0;
    localparam logic RXW_WDT_RUN_RST = 1'b1;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] x;
        logic [3:0] y;
        logic [3:0] mem;
    } rxw_regs_s;

    typedef enum logic [3:0] {
        RXW_OP_NONE = 4'b0001,
        RXW_OP_WT = 4'b0010,
        RXW_OP_SW = 4'b0100,
        RXW_OP_SWD = 4'b1000
    } rxw_op_e;
endpackage
